// *** hw/pmsb_regs.svh ***
// constants for the power manager status bank: command codes, bit positions, reset values
`ifndef PMSB_REGS_SVH
`define PMSB_REGS_SVH

`define PMSB_CMD_CLEAR_FAULTS 8'h03
`define PMSB_CMD_OUT_V_STAT   8'h7a
`define PMSB_CMD_OUT_I_STAT   8'h7b
`define PMSB_CMD_IN_STAT      8'h7c
`define PMSB_CMD_TEMP_STAT    8'h7d
`define PMSB_CMD_CML_STAT     8'h7e
`define PMSB_CMD_VEND_STAT    8'h80
`define PMSB_CMD_PAD_WORD     8'he5

`define PMSB_BIT_OV_FAULT     7
`define PMSB_BIT_OV_WARN      6
`define PMSB_BIT_UV_WARN      5
`define PMSB_BIT_UV_FAULT     4
`define PMSB_BIT_VMAX_WARN    3
`define PMSB_BIT_TON_MAX      2
`define PMSB_BIT_OC_FAULT     7
`define PMSB_BIT_OC_WARN      5
`define PMSB_BIT_UC_FAULT     4
`define PMSB_BIT_IN_OFF       3
`define PMSB_BIT_CMD_FAULT    7
`define PMSB_BIT_DATA_FAULT   6
`define PMSB_BIT_PEC_FAULT    5
`define PMSB_BIT_MEM_FAULT    4
`define PMSB_BIT_BUS_FAULT    1
`define PMSB_BIT_DISCHARGE    7
`define PMSB_BIT_FLINE1       6
`define PMSB_BIT_FLINE0       5
`define PMSB_BIT_SERVO_OK     4
`define PMSB_BIT_DAC_CONN     3
`define PMSB_BIT_DAC_SAT      2
`define PMSB_BIT_AUX_OFF      1
`define PMSB_BIT_WATCHDOG     0

`define PMSB_MASK_VOUT        8'hfc
`define PMSB_MASK_IOUT        8'hb0
`define PMSB_MASK_INPUT       8'hf8
`define PMSB_MASK_TEMP        8'hf0
`define PMSB_MASK_CML         8'hf2
`define PMSB_MASK_VEND_STICKY 8'he4
`define PMSB_BYTE_RESET       8'h00
`define PMSB_PAGE_ALL         8'hff

`define PMSB_ASEL_HIGH        2'b11
`define PMSB_ASEL_FLOAT       2'b10
`define PMSB_ASEL_LOW         2'b00
`define PMSB_PAD_RSVD         2'b00

`endif

// *** hw/pmsb_pkg.sv ***
// types for the power manager status bank
package pmsb_pkg;
  typedef logic [7:0] pmsb_byte_t;
  typedef enum logic [2:0] {
    PMSB_PAD_LOW   = 3'b001,
    PMSB_PAD_FLOAT = 3'b010,
    PMSB_PAD_HIGH  = 3'b100
  } pmsb_pad_t;
endpackage

// *** hw/pmsb_sync2.sv ***
// two-flop synchroniser for a bus of pad levels
`timescale 1ns/1ps
module pmsb_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  always_comb begin
    next_stage1 = d;
    next_q      = stage1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= next_stage1;
      q      <= next_q;
    end
  end
endmodule

// *** hw/pmsb_status_bank.sv ***
// status register bank of the four-channel power manager
`timescale 1ns/1ps
`include "pmsb_regs.svh"
module pmsb_status_bank
  import pmsb_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic [7:0]  PAGE,
  input  wire logic [7:0]  READ_CMD,
  output logic      [15:0] READ_DATA,
  output logic             READ_VALID,
  input  wire logic        CLEAR_FAULTS,
  input  wire logic [3:0]  CHAN_ON_CMD,
  input  wire logic [3:0]  VOUT_OV_FAULT,
  input  wire logic [3:0]  VOUT_OV_WARN,
  input  wire logic [3:0]  VOUT_UV_WARN,
  input  wire logic [3:0]  VOUT_UV_FAULT,
  input  wire logic [3:0]  VOUT_MAX_REQ,
  input  wire logic [3:0]  TON_MAX_FAULT,
  input  wire logic [3:0]  IOUT_OC_FAULT,
  input  wire logic [3:0]  IOUT_OC_WARN,
  input  wire logic [3:0]  IOUT_UC_FAULT,
  input  wire logic [3:0]  TEMP_OT_FAULT,
  input  wire logic [3:0]  TEMP_OT_WARN,
  input  wire logic [3:0]  TEMP_UT_WARN,
  input  wire logic [3:0]  TEMP_UT_FAULT,
  input  wire logic        VIN_OV_FAULT,
  input  wire logic        VIN_OV_WARN,
  input  wire logic        VIN_UV_WARN,
  input  wire logic        VIN_UV_FAULT,
  input  wire logic        VIN_OFF,
  input  wire logic        CML_CMD_FAULT,
  input  wire logic        CML_DATA_FAULT,
  input  wire logic        CML_EXTRA_BYTE,
  input  wire logic        CML_PEC_MATCH,
  input  wire logic        CML_MEM_FAULT,
  input  wire logic        CML_BUS_FAULT,
  input  wire logic [3:0]  DISCHARGE_FAULT,
  input  wire logic [3:0]  TURN_ON_TRY,
  input  wire logic [3:0]  FAULT_LINE0_SHUTDOWN,
  input  wire logic [3:0]  FAULT_LINE1_SHUTDOWN,
  input  wire logic [3:0]  SERVO_TARGET_REACHED,
  input  wire logic [3:0]  DAC_CONNECTED,
  input  wire logic [3:0]  DAC_SATURATED,
  input  wire logic [3:0]  AUX_FAULT_RELEASED,
  input  wire logic        WATCHDOG_FAULT,
  input  wire logic        PWRGD_DRIVE_LOW,
  input  wire logic [1:0]  FAULT_DRIVE_LOW,
  input  wire logic        SHARED_FAULT_LINE_0_N,
  input  wire logic        SHARED_FAULT_LINE_1_N,
  input  wire logic        ADDR_SELECT_PAD_0,
  input  wire logic        ADDR_SELECT_PAD_0_FLOAT,
  input  wire logic        ADDR_SELECT_PAD_1,
  input  wire logic        ADDR_SELECT_PAD_1_FLOAT,
  input  wire logic        ON_OFF_PAD_0,
  input  wire logic        ON_OFF_PAD_1,
  input  wire logic        ON_OFF_PAD_2,
  input  wire logic        ON_OFF_PAD_3,
  input  wire logic        ALERT_N_IN,
  output logic             ALERT_N_OUT,
  output logic             ALERT_N_OE
);

  pmsb_byte_t vout_stat [4];
  pmsb_byte_t iout_stat [4];
  pmsb_byte_t temp_stat [4];
  pmsb_byte_t vend_stat [4];
  pmsb_byte_t next_vout [4];
  pmsb_byte_t next_iout [4];
  pmsb_byte_t next_temp [4];
  pmsb_byte_t next_vend [4];
  pmsb_byte_t input_stat;
  pmsb_byte_t next_input;
  pmsb_byte_t cml_stat;
  pmsb_byte_t next_cml;
  logic       watchdog;
  logic       next_watchdog;
  logic       alert_hold;
  logic       next_alert_hold;
  logic [3:0] page_clear;
  logic [3:0] alert_set;
  logic [15:0] pad_word;
  logic [15:0] next_read_data;
  logic        next_read_valid;
  logic [9:0]  pad_raw;
  logic [9:0]  pad_sync;
  logic [1:0]  addr_select_pad_0_code;
  logic [1:0]  addr_select_pad_1_code;
  pmsb_pad_t   addr_select_pad_0_state;
  pmsb_pad_t   addr_select_pad_1_state;
  logic [7:0]  rd_page;

  // raw pads go straight to the synchroniser, bypassing deglitch filters
  assign pad_raw = {SHARED_FAULT_LINE_0_N, SHARED_FAULT_LINE_1_N, ADDR_SELECT_PAD_0, ADDR_SELECT_PAD_0_FLOAT,
                    ADDR_SELECT_PAD_1, ADDR_SELECT_PAD_1_FLOAT, ON_OFF_PAD_0, ON_OFF_PAD_1,
                    ON_OFF_PAD_2, ON_OFF_PAD_3};

  pmsb_sync2 #(.W(10)) u_pad_sync (
    .clock (CLOCK),
    .reset (RESET),
    .d     (pad_raw),
    .q     (pad_sync)
  );

  // clear-faults reaches the selected channel or every channel on the global page
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      page_clear[c] = CLEAR_FAULTS && (PAGE == `PMSB_PAGE_ALL || PAGE == 8'(c));
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      always_comb begin
        next_vout[ch] = page_clear[ch] ? `PMSB_BYTE_RESET : vout_stat[ch];
        next_iout[ch] = page_clear[ch] ? `PMSB_BYTE_RESET : iout_stat[ch];
        next_temp[ch] = page_clear[ch] ? `PMSB_BYTE_RESET : temp_stat[ch];
        // sticky vendor bits fall on clear or when channel is commanded on
        next_vend[ch] = (page_clear[ch] || CHAN_ON_CMD[ch]) ? `PMSB_BYTE_RESET
                        : (vend_stat[ch] & `PMSB_MASK_VEND_STICKY);
        // voltage faults and warnings; set beats clear
        next_vout[ch][`PMSB_BIT_OV_FAULT] = next_vout[ch][`PMSB_BIT_OV_FAULT] | VOUT_OV_FAULT[ch];
        next_vout[ch][`PMSB_BIT_OV_WARN]  = next_vout[ch][`PMSB_BIT_OV_WARN] | VOUT_OV_WARN[ch];
        next_vout[ch][`PMSB_BIT_UV_WARN]  = next_vout[ch][`PMSB_BIT_UV_WARN] | VOUT_UV_WARN[ch];
        next_vout[ch][`PMSB_BIT_UV_FAULT] = next_vout[ch][`PMSB_BIT_UV_FAULT] | VOUT_UV_FAULT[ch];
        next_vout[ch][`PMSB_BIT_VMAX_WARN] = next_vout[ch][`PMSB_BIT_VMAX_WARN] | VOUT_MAX_REQ[ch];
        // turn-on time fault, low bits forced zero
        next_vout[ch][`PMSB_BIT_TON_MAX] = next_vout[ch][`PMSB_BIT_TON_MAX] | TON_MAX_FAULT[ch];
        next_vout[ch] = next_vout[ch] & `PMSB_MASK_VOUT;
        next_iout[ch][`PMSB_BIT_OC_FAULT] = next_iout[ch][`PMSB_BIT_OC_FAULT] | IOUT_OC_FAULT[ch];
        next_iout[ch][`PMSB_BIT_OC_WARN]  = next_iout[ch][`PMSB_BIT_OC_WARN] | IOUT_OC_WARN[ch];
        next_iout[ch][`PMSB_BIT_UC_FAULT] = next_iout[ch][`PMSB_BIT_UC_FAULT] | IOUT_UC_FAULT[ch];
        next_iout[ch] = next_iout[ch] & `PMSB_MASK_IOUT;
        next_temp[ch][`PMSB_BIT_OV_FAULT] = next_temp[ch][`PMSB_BIT_OV_FAULT] | TEMP_OT_FAULT[ch];
        next_temp[ch][`PMSB_BIT_OV_WARN]  = next_temp[ch][`PMSB_BIT_OV_WARN] | TEMP_OT_WARN[ch];
        next_temp[ch][`PMSB_BIT_UV_WARN]  = next_temp[ch][`PMSB_BIT_UV_WARN] | TEMP_UT_WARN[ch];
        next_temp[ch][`PMSB_BIT_UV_FAULT] = next_temp[ch][`PMSB_BIT_UV_FAULT] | TEMP_UT_FAULT[ch];
        next_temp[ch] = next_temp[ch] & `PMSB_MASK_TEMP;
        next_vend[ch][`PMSB_BIT_DISCHARGE] = next_vend[ch][`PMSB_BIT_DISCHARGE] | DISCHARGE_FAULT[ch];
        // fault line low at turn-on, or shutdown caused by it
        next_vend[ch][`PMSB_BIT_FLINE1] = next_vend[ch][`PMSB_BIT_FLINE1]
                                          | (TURN_ON_TRY[ch] & ~pad_sync[8]) | FAULT_LINE1_SHUTDOWN[ch];
        next_vend[ch][`PMSB_BIT_FLINE0] = next_vend[ch][`PMSB_BIT_FLINE0]
                                          | (TURN_ON_TRY[ch] & ~pad_sync[9]) | FAULT_LINE0_SHUTDOWN[ch];
        // live servo and DAC state, sticky saturation
        next_vend[ch][`PMSB_BIT_SERVO_OK] = SERVO_TARGET_REACHED[ch];
        next_vend[ch][`PMSB_BIT_DAC_CONN] = DAC_CONNECTED[ch];
        next_vend[ch][`PMSB_BIT_DAC_SAT]  = next_vend[ch][`PMSB_BIT_DAC_SAT] | DAC_SATURATED[ch];
        // live auxiliary release; bit 0 is filled from the unpaged watchdog at read time
        next_vend[ch][`PMSB_BIT_AUX_OFF]  = AUX_FAULT_RELEASED[ch];
        next_vend[ch][`PMSB_BIT_WATCHDOG] = 1'b0;
      end

      // alerting vendor bits newly set on this channel
      assign alert_set[ch] = DISCHARGE_FAULT[ch] | FAULT_LINE0_SHUTDOWN[ch] | FAULT_LINE1_SHUTDOWN[ch]
                             | (TURN_ON_TRY[ch] & ~(pad_sync[8] & pad_sync[9]));

      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          vout_stat[ch] <= `PMSB_BYTE_RESET;
          iout_stat[ch] <= `PMSB_BYTE_RESET;
          temp_stat[ch] <= `PMSB_BYTE_RESET;
          vend_stat[ch] <= `PMSB_BYTE_RESET;
        end else begin
          vout_stat[ch] <= next_vout[ch];
          iout_stat[ch] <= next_iout[ch];
          temp_stat[ch] <= next_temp[ch];
          vend_stat[ch] <= next_vend[ch];
        end
      end
    end
  endgenerate

  // unpaged registers clear on any clear-faults regardless of page
  always_comb begin
    next_input = CLEAR_FAULTS ? `PMSB_BYTE_RESET : input_stat;
    next_cml   = CLEAR_FAULTS ? `PMSB_BYTE_RESET : cml_stat;
    next_input[`PMSB_BIT_OV_FAULT] = next_input[`PMSB_BIT_OV_FAULT] | VIN_OV_FAULT;
    next_input[`PMSB_BIT_OV_WARN]  = next_input[`PMSB_BIT_OV_WARN] | VIN_OV_WARN;
    next_input[`PMSB_BIT_UV_WARN]  = next_input[`PMSB_BIT_UV_WARN] | VIN_UV_WARN;
    next_input[`PMSB_BIT_UV_FAULT] = next_input[`PMSB_BIT_UV_FAULT] | VIN_UV_FAULT;
    next_input[`PMSB_BIT_IN_OFF] = next_input[`PMSB_BIT_IN_OFF] | VIN_OFF;
    next_input = next_input & `PMSB_MASK_INPUT;
    next_cml[`PMSB_BIT_CMD_FAULT] = next_cml[`PMSB_BIT_CMD_FAULT] | CML_CMD_FAULT;
    next_cml[`PMSB_BIT_DATA_FAULT] = next_cml[`PMSB_BIT_DATA_FAULT] | CML_DATA_FAULT;
    // extra byte that is not a matching check byte
    next_cml[`PMSB_BIT_PEC_FAULT] = next_cml[`PMSB_BIT_PEC_FAULT] | (CML_EXTRA_BYTE & ~CML_PEC_MATCH);
    next_cml[`PMSB_BIT_MEM_FAULT] = next_cml[`PMSB_BIT_MEM_FAULT] | CML_MEM_FAULT;
    next_cml[`PMSB_BIT_BUS_FAULT] = next_cml[`PMSB_BIT_BUS_FAULT] | CML_BUS_FAULT;
    next_cml = next_cml & `PMSB_MASK_CML;
    // watchdog is unpaged; on/off commands of one channel do not clear it
    next_watchdog = (watchdog & ~CLEAR_FAULTS) | WATCHDOG_FAULT;
    // alert held low from an alerting event until clear-faults; set wins
    next_alert_hold = (alert_hold & ~CLEAR_FAULTS) | (|alert_set) | WATCHDOG_FAULT;
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      input_stat <= `PMSB_BYTE_RESET;
      cml_stat   <= `PMSB_BYTE_RESET;
      watchdog   <= 1'b0;
      alert_hold <= 1'b0;
    end else begin
      input_stat <= next_input;
      cml_stat   <= next_cml;
      watchdog   <= next_watchdog;
      alert_hold <= next_alert_hold;
    end
  end

  // open-drain alert: enable low means the pin is pulled low
  assign ALERT_N_OUT = 1'b0;
  assign ALERT_N_OE  = ~alert_hold;

  // address pad decode; float wins over a sampled level
  always_comb begin
    addr_select_pad_0_state = pad_sync[6] ? PMSB_PAD_FLOAT : (pad_sync[7] ? PMSB_PAD_HIGH : PMSB_PAD_LOW);
    addr_select_pad_1_state = pad_sync[4] ? PMSB_PAD_FLOAT : (pad_sync[5] ? PMSB_PAD_HIGH : PMSB_PAD_LOW);
    case (addr_select_pad_0_state)
      PMSB_PAD_HIGH:  addr_select_pad_0_code = `PMSB_ASEL_HIGH;
      PMSB_PAD_FLOAT: addr_select_pad_0_code = `PMSB_ASEL_FLOAT;
      default:        addr_select_pad_0_code = `PMSB_ASEL_LOW;
    endcase
    case (addr_select_pad_1_state)
      PMSB_PAD_HIGH:  addr_select_pad_1_code = `PMSB_ASEL_HIGH;
      PMSB_PAD_FLOAT: addr_select_pad_1_code = `PMSB_ASEL_FLOAT;
      default:        addr_select_pad_1_code = `PMSB_ASEL_LOW;
    endcase
  end

  // drive-state bits are 0 while this chip pulls the line low
  // raw pad levels, fault line 0 in bit 3
  assign pad_word = {~PWRGD_DRIVE_LOW, alert_hold ? 1'b0 : 1'b1, ~FAULT_DRIVE_LOW, `PMSB_PAD_RSVD,
                     addr_select_pad_1_code, addr_select_pad_0_code, pad_sync[2], pad_sync[3], pad_sync[9], pad_sync[8],
                     pad_sync[1], pad_sync[0]};

  // reads only sample state; nothing is cleared by reading
  always_comb begin
    rd_page         = (PAGE > 8'h03) ? 8'h00 : PAGE;
    next_read_valid = 1'b1;
    case (READ_CMD)
      `PMSB_CMD_OUT_V_STAT: next_read_data = {8'h00, vout_stat[rd_page[1:0]]};
      `PMSB_CMD_OUT_I_STAT: next_read_data = {8'h00, iout_stat[rd_page[1:0]]};
      `PMSB_CMD_IN_STAT:    next_read_data = {8'h00, input_stat};
      `PMSB_CMD_TEMP_STAT:  next_read_data = {8'h00, temp_stat[rd_page[1:0]]};
      `PMSB_CMD_CML_STAT:   next_read_data = {8'h00, cml_stat};
      `PMSB_CMD_VEND_STAT:  next_read_data = {8'h00, vend_stat[rd_page[1:0]][7:1], watchdog};
      `PMSB_CMD_PAD_WORD:   next_read_data = pad_word;
      default: begin
        next_read_data  = 16'h0000;
        next_read_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      READ_DATA  <= 16'h0000;
      READ_VALID <= 1'b0;
    end else begin
      READ_DATA  <= next_read_data;
      READ_VALID <= next_read_valid;
    end
  end

  property p_vout_ov_sets;
    @(posedge CLOCK) disable iff (RESET) VOUT_OV_FAULT[0] |=> vout_stat[0][7];
  endproperty
  a_vout_ov_sets: assert property (p_vout_ov_sets) else $error("ov fault not latched");
  property p_vout_low_zero;
    @(posedge CLOCK) disable iff (RESET) vout_stat[1][1:0] == 2'b00;
  endproperty
  a_vout_low_zero: assert property (p_vout_low_zero) else $error("voltage low bits set");
  property p_pec_match;
    @(posedge CLOCK) disable iff (RESET) (CML_EXTRA_BYTE && !CML_PEC_MATCH) |=> cml_stat[5];
  endproperty
  a_pec_match: assert property (p_pec_match) else $error("check byte fault missed");
  sequence s_alert_evt;
    DISCHARGE_FAULT[0] || WATCHDOG_FAULT;
  endsequence
  property p_alert_low;
    @(posedge CLOCK) disable iff (RESET) s_alert_evt ##1 !CLEAR_FAULTS[*1] |=> !ALERT_N_OE;
  endproperty
  a_alert_low: assert property (p_alert_low) else $error("alert not driven");
  property p_clear_release;
    @(posedge CLOCK) disable iff (RESET) (CLEAR_FAULTS && !(|alert_set) && !WATCHDOG_FAULT) |=> ALERT_N_OE;
  endproperty
  a_clear_release: assert property (p_clear_release) else $error("alert not released");
  property p_sticky_hold;
    @(posedge CLOCK) disable iff (RESET)
      (vend_stat[2][`PMSB_BIT_FLINE1] && !page_clear[2] && !CHAN_ON_CMD[2]) |=> vend_stat[2][`PMSB_BIT_FLINE1];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky bit lost");
  property p_set_beats_clear;
    @(posedge CLOCK) disable iff (RESET) (CLEAR_FAULTS && VIN_UV_FAULT) |=> input_stat[4];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("refault lost at clear");
  property p_read_no_clear;
    @(posedge CLOCK) disable iff (RESET)
      (READ_CMD == `PMSB_CMD_CML_STAT && cml_stat[7] && !CLEAR_FAULTS) |=> cml_stat[7];
  endproperty
  a_read_no_clear: assert property (p_read_no_clear) else $error("read cleared a flag");
  property p_pad_rsvd;
    @(posedge CLOCK) disable iff (RESET) pad_word[11:10] == 2'b00 && pad_word[14] == ALERT_N_OE;
  endproperty
  a_pad_rsvd: assert property (p_pad_rsvd) else $error("pad word drive bits wrong");
endmodule

// *** testbench/pmsb_host_model.sv ***
// management bus host model: issues status reads and captures the answer
`timescale 1ns/1ps
module pmsb_host_model (
  input  wire logic        clock,
  output logic      [7:0]  read_cmd,
  output logic      [7:0]  page,
  input  wire logic [15:0] read_data,
  input  wire logic        read_valid
);
  initial begin
    read_cmd = 8'h00;
    page     = 8'h00;
  end
  // command and page are held over the answer edge, so a slow bank still sees a steady request
  task automatic rd(input logic [7:0] c, input logic [7:0] p, output logic [15:0] d, output logic v);
    @(posedge clock);
    read_cmd <= c;
    page     <= p;
    @(posedge clock);
    #1;
    d = read_data;
    v = read_valid;
  endtask
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the power manager status bank
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] RC [6]  = '{8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80};
  localparam int         PB [15] = '{7, 6, 5, 4, 3, 2, 7, 5, 4, 7, 6, 5, 4, 7, 2};
  localparam int         SB [11] = '{7, 6, 5, 4, 3, 7, 6, 5, 4, 1, 0};
  logic        clock, reset, clear, pec_match, pwrgd_low, fl0_n, fl1_n, as0, as0_f, as1, as1_f;
  logic [3:0]  pe [19];
  logic        sb [11];
  logic [11:0] lv;
  logic [3:0]  pads_on;
  logic [1:0]  fdl;
  logic [7:0]  read_cmd, page, c, ch;
  logic [15:0] read_data, d;
  logic        read_valid, v, alert_out, alert_oe;
  int          n_mismatch, comparisons;
  // alert line has a pull-up: released means high
  wire         alert_pin = alert_oe ? 1'b1 : alert_out;

  pmsb_host_model host (.clock(clock), .read_cmd(read_cmd), .page(page), .read_data(read_data),
    .read_valid(read_valid));
  pmsb_status_bank uut (
    .CLOCK(clock), .RESET(reset), .PAGE(page), .READ_CMD(read_cmd), .READ_DATA(read_data),
    .READ_VALID(read_valid), .CLEAR_FAULTS(clear), .CHAN_ON_CMD(pe[18]),
    .VOUT_OV_FAULT(pe[0]), .VOUT_OV_WARN(pe[1]), .VOUT_UV_WARN(pe[2]), .VOUT_UV_FAULT(pe[3]),
    .VOUT_MAX_REQ(pe[4]), .TON_MAX_FAULT(pe[5]), .IOUT_OC_FAULT(pe[6]), .IOUT_OC_WARN(pe[7]),
    .IOUT_UC_FAULT(pe[8]), .TEMP_OT_FAULT(pe[9]), .TEMP_OT_WARN(pe[10]), .TEMP_UT_WARN(pe[11]),
    .TEMP_UT_FAULT(pe[12]), .DISCHARGE_FAULT(pe[13]), .DAC_SATURATED(pe[14]), .TURN_ON_TRY(pe[15]),
    .FAULT_LINE0_SHUTDOWN(pe[16]), .FAULT_LINE1_SHUTDOWN(pe[17]), .VIN_OV_FAULT(sb[0]),
    .VIN_OV_WARN(sb[1]), .VIN_UV_WARN(sb[2]), .VIN_UV_FAULT(sb[3]), .VIN_OFF(sb[4]),
    .CML_CMD_FAULT(sb[5]), .CML_DATA_FAULT(sb[6]), .CML_EXTRA_BYTE(sb[7]), .CML_PEC_MATCH(pec_match),
    .CML_MEM_FAULT(sb[8]), .CML_BUS_FAULT(sb[9]), .WATCHDOG_FAULT(sb[10]),
    .SERVO_TARGET_REACHED(lv[11:8]), .DAC_CONNECTED(lv[7:4]), .AUX_FAULT_RELEASED(lv[3:0]),
    .PWRGD_DRIVE_LOW(pwrgd_low), .FAULT_DRIVE_LOW(fdl), .SHARED_FAULT_LINE_0_N(fl0_n),
    .SHARED_FAULT_LINE_1_N(fl1_n), .ADDR_SELECT_PAD_0(as0), .ADDR_SELECT_PAD_0_FLOAT(as0_f),
    .ADDR_SELECT_PAD_1(as1), .ADDR_SELECT_PAD_1_FLOAT(as1_f), .ON_OFF_PAD_0(pads_on[0]),
    .ON_OFF_PAD_1(pads_on[1]), .ON_OFF_PAD_2(pads_on[2]), .ON_OFF_PAD_3(pads_on[3]),
    .ALERT_N_IN(alert_pin), .ALERT_N_OUT(alert_out), .ALERT_N_OE(alert_oe)
  );

  task automatic chk(input logic [15:0] e, input logic [15:0] g, input string nm);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] cm, input logic [7:0] p, input logic [15:0] e);
    host.rd(cm, p, d, v);
    chk(e, d, $sformatf("data cmd %h page %h", cm, p));
    chk(16'h1, {15'h0, v}, "read valid");
  endtask
  task automatic clr(input logic [7:0] p);
    host.rd(8'h00, p, d, v);
    @(posedge clock) clear <= 1'b1;
    @(posedge clock) clear <= 1'b0;
  endtask
  task automatic pp(input int i, input logic [3:0] m);
    @(posedge clock) pe[i] <= m;
    @(posedge clock) pe[i] <= 4'h0;
  endtask
  task automatic sp(input int i);
    @(posedge clock) sb[i] <= 1'b1;
    @(posedge clock) sb[i] <= 1'b0;
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // a few hundred cycles are expected; the limit leaves ample slack
  initial begin
    #20000;
    n_mismatch++;
    test_done();
  end
  initial begin
    foreach (pe[i]) pe[i] = 4'h0;
    foreach (sb[i]) sb[i] = 1'b0;
    {clear, pec_match, pwrgd_low, as0, as0_f, as1, as1_f} = '0;
    {fdl, lv, pads_on} = '0;
    {fl0_n, fl1_n} = 2'b11;
    reset = 1'b1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 6; i++) rc(RC[i], 8'h00, 16'h0000);
    rc(8'he5, 8'h00, 16'hf00c);
    for (int i = 0; i < 15; i++) begin
      ch = 8'(i % 4);
      c = (i < 6) ? 8'h7a : (i < 9) ? 8'h7b : (i < 13) ? 8'h7d : 8'h80;
      pp(i, 4'h1 << ch);
      rc(c, ch, 16'h1 << PB[i]);
      chk((i == 13) ? 16'h0 : 16'h1, {15'h0, alert_pin}, "alert pin");
      rc(c, (ch + 8'h1) & 8'h3, 16'h0000);
      clr(ch);
      rc(c, ch, 16'h0000);
      chk(16'h1, {15'h0, alert_pin}, "alert pin");
    end
    for (int i = 0; i < 11; i++) begin
      c = (i < 5) ? 8'h7c : (i < 10) ? 8'h7e : 8'h80;
      sp(i);
      rc(c, 8'h03, 16'h1 << SB[i]);
      chk((i == 10) ? 16'h0 : 16'h1, {15'h0, alert_pin}, "alert pin");
      clr(8'h02);
      rc(c, 8'h01, 16'h0000);
    end
    @(posedge clock) pec_match <= 1'b1;
    sp(7);
    pec_match <= 1'b0;
    rc(8'h7e, 8'h00, 16'h0000);
    @(posedge clock) fl1_n <= 1'b0;
    repeat (3) @(posedge clock);
    pp(15, 4'h4);
    rc(8'h80, 8'h02, 16'h0040);
    chk(16'h0, {15'h0, alert_pin}, "alert pin");
    rc(8'h80, 8'h02, 16'h0040);
    pp(18, 4'h4);
    rc(8'h80, 8'h02, 16'h0000);
    @(posedge clock) fl1_n <= 1'b1;
    pp(16, 4'h2);
    rc(8'h80, 8'h01, 16'h0020);
    clr(8'hff);
    rc(8'h80, 8'h01, 16'h0000);
    chk(16'h1, {15'h0, alert_pin}, "alert pin");
    @(posedge clock) lv <= 12'h888;
    rc(8'h80, 8'h03, 16'h001a);
    @(posedge clock) lv <= 12'h000;
    rc(8'h80, 8'h03, 16'h0000);
    @(posedge clock) begin
      pe[0] <= 4'h1;
      sb[3] <= 1'b1;
    end
    clr(8'h00);
    rc(8'h7a, 8'h00, 16'h0080);
    rc(8'h7c, 8'h00, 16'h0010);
    @(posedge clock) begin
      pe[0] <= 4'h0;
      sb[3] <= 1'b0;
    end
    clr(8'h00);
    rc(8'h7a, 8'h00, 16'h0000);
    rc(8'h7c, 8'h00, 16'h0000);
    @(posedge clock) begin
      {pwrgd_low, fdl, fl0_n, as1_f, as0} <= 6'b110011;
      pads_on <= 4'b0101;
    end
    repeat (3) @(posedge clock);
    rc(8'he5, 8'h00, 16'h52d6);
    @(posedge clock) begin
      {pwrgd_low, fdl, fl0_n, fl1_n, as1_f, as0_f} <= 7'b0011001;
      as1 <= 1'b1;
      pads_on <= 4'b1010;
    end
    repeat (3) @(posedge clock);
    rc(8'he5, 8'h00, 16'he3a9);
    host.rd(8'h55, 8'h00, d, v);
    chk(16'h0, d, "unknown command data");
    chk(16'h0, {15'h0, v}, "unknown command valid");
    test_done();
  end
endmodule
